// >>> dv/bsc_strap_board.sv
// board strap resistors, pins turning into port outputs after reset
`timescale 1ns/100ps
`default_nettype none
module bsc_strap_board (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [19:0] pull_map,
	output var logic [15:0] strap_inputs,
	output var logic [3:0] port_tx_enable_user_strap
);
	logic live_q;
	logic tog_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			live_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
			tog_q <= ~tog_q;
		end
	end
	// pull-up reads one, pull-down zero, held over the capture edge
	// then the shared pins toggle every cycle
	always_comb begin
		{port_tx_enable_user_strap, strap_inputs} = live_q ? ~pull_map ^ {20{tog_q}} : pull_map;
	end
endmodule : bsc_strap_board
`default_nettype wire

// >>> dv/bsc_strap_capture_asserts.sv
// concurrent checks on the strap capture ports
`timescale 1ns/100ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_strap_capture_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] strap_inputs,
	input wire logic mgmt_strobe_in,
	input wire logic mgmt_strobe_q,
	input wire logic straps_valid_q,
	input wire logic par16_sel_q,
	input wire logic par8_sel_q,
	input wire logic serial_mii_sel_q,
	input wire logic serial_only_sel_q,
	input wire logic unmanaged_sel_q,
	input wire logic mode_invalid_q,
	input wire logic cpu_frames_mii_q,
	input wire logic cpu_frames_serial_q,
	input wire logic eeprom_boot_allow_q,
	input wire logic [2:0] serial_dev_addr_q,
	input wire logic module_detect_en_q,
	input wire logic mac_power_save_en_q,
	input wire logic [3:0] user_strap_q
);
	logic up_q;
	logic [15:0] cap_q;
	logic [2:0] m;
	assign m = cap_q[`BSC_MODE_MSB:`BSC_MODE_LSB];
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_q <= 1'b0;
			cap_q <= 16'h0000;
		end else if (!up_q) begin
			up_q <= 1'b1;
			cap_q <= strap_inputs;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	valid_rise_a: assert property (up_q |=> straps_valid_q) else $error("valid late");
	par_sel_a: assert property (straps_valid_q |-> par16_sel_q == (m == `BSC_MODE_PAR16)
		&& par8_sel_q == (m == `BSC_MODE_PAR8)) else $error("parallel select");
	serial_sel_a: assert property (straps_valid_q |-> serial_mii_sel_q == (m == 3'h2)
		&& cpu_frames_mii_q == serial_mii_sel_q && serial_only_sel_q == (m == 3'h3)
		&& cpu_frames_serial_q == serial_only_sel_q) else $error("serial select");
	unmanaged_sel_a: assert property (straps_valid_q |-> unmanaged_sel_q == (m == 3'h7)
		&& eeprom_boot_allow_q == unmanaged_sel_q) else $error("unmanaged select");
	dev_addr_a: assert property (straps_valid_q |-> serial_dev_addr_q == cap_q[6:4])
		else $error("device address");
	psave_gate_a: assert property (straps_valid_q && mac_power_save_en_q |-> cap_q[11])
		else $error("power save");
	detect_gate_a: assert property (straps_valid_q && module_detect_en_q |-> cap_q[9])
		else $error("module detect");
	mode_invalid_a: assert property (straps_valid_q |->
		mode_invalid_q == (m > 3'h3 && m < 3'h7)) else $error("invalid mode");
	user_hold_a: assert property (straps_valid_q |=> $stable(user_strap_q))
		else $error("user bits moved");
	raw_strobe_a: assert property (straps_valid_q && !cap_q[0] |=>
		mgmt_strobe_q == $past(mgmt_strobe_in)) else $error("raw strobe");
endmodule : bsc_strap_capture_chk
bind bsc_strap_capture bsc_strap_capture_chk i_chk (.core_clk, .rst_b, .strap_inputs,
	.mgmt_strobe_in, .mgmt_strobe_q, .straps_valid_q, .par16_sel_q, .par8_sel_q,
	.serial_mii_sel_q, .serial_only_sel_q, .unmanaged_sel_q, .cpu_frames_mii_q,
	.cpu_frames_serial_q, .eeprom_boot_allow_q, .serial_dev_addr_q, .mac_power_save_en_q,
	.user_strap_q, .mode_invalid_q, .module_detect_en_q);
`default_nettype wire

// >>> dv/test_bootstrap_strap_capture.sv
// self-checking bench for the strap capture block
`timescale 1ns/100ps
`default_nettype none
`include "bsc_cfg.svh"
module test_bootstrap_strap_capture;
	logic core_clk, rst_b, strobe_in, hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, rd, w;
	logic [19:0] pm;
	wire hready, hresp, strobe_q, valid, det, ps, inv;
	wire [31:0] hrdata;
	wire [15:0] strap;
	wire [4:0] sel;
	wire [3:0] user, ustr;
	wire [2:0] frm, addr_q;
	int bad_count, num_checks, cyc, m;
	localparam int DEB = 2;
	bsc_strap_capture #(.DEB_CYCLES(DEB)) i_dut (.core_clk, .rst_b, .strap_inputs(strap),
		.port_tx_enable_user_strap(user), .mgmt_strobe_in(strobe_in), .mgmt_strobe_q(strobe_q),
		.straps_valid_q(valid), .par16_sel_q(sel[4]), .par8_sel_q(sel[3]),
		.serial_mii_sel_q(sel[2]), .serial_only_sel_q(sel[1]), .unmanaged_sel_q(sel[0]),
		.mode_invalid_q(inv), .cpu_frames_mii_q(frm[2]), .cpu_frames_serial_q(frm[1]),
		.eeprom_boot_allow_q(frm[0]), .serial_dev_addr_q(addr_q), .module_detect_en_q(det),
		.mac_power_save_en_q(ps), .user_strap_q(ustr), .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp);
	bsc_strap_board i_board (.core_clk, .rst_b, .pull_map(pm), .strap_inputs(strap),
		.port_tx_enable_user_strap(user));
	always #10 core_clk = ~core_clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		hwrite <= wr;
		haddr <= {24'h0000_00, a};
		htrans <= 2'h2;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		strobe_in = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = `BSC_HSIZE_WORD;
		haddr = '0;
		hwdata = '0;
		pm = '0;
		void'($urandom(32'h6400_6431));
		for (int i = 0; i < 10; i++) begin
			w = $urandom();
			w[3:1] = i[2:0];
			w[0] = i[1];
			@(posedge core_clk);
			rst_b <= 1'b0;
			strobe_in <= 1'b0;
			pm <= w[19:0];
			repeat (3) @(posedge core_clk);
			rst_b <= 1'b1;
			repeat (3) @(posedge core_clk);
			#1;
			m = pm[3:1];
			check("select", sel, {m == 0, m == 1, m == 2, m == 3, m == 7});
			check("frames", frm, {m == 2, m == 3, m == 7});
			check("invalid", {inv, hresp}, {m > 3 && m < 7, 1'b0});
			check("address", addr_q, pm[6:4]);
			check("enables", {det, ps}, {pm[9], pm[11]});
			check("user", {valid, ustr}, {1'b1, pm[19:16]});
			bus(1'b0, `BSC_OFF_STATUS, 32'h0);
			check("status", rd, {m > 3 && m < 7, pm[11], pm[9], pm[6:0]} | 32'h400);
			bus(1'b0, `BSC_OFF_USER, 32'h0);
			check("readback", rd, pm[19:16]);
			bus(1'b0, `BSC_OFF_RAW, 32'h0);
			check("raw", rd, pm[15:0]);
			bus(1'b0, 8'h10, 32'h0);
			check("unmapped", rd, 32'h0);
			w = $urandom();
			bus(1'b1, `BSC_OFF_CTRL, w);
			bus(1'b0, `BSC_OFF_CTRL, 32'h0);
			#1;
			check("ctrl", rd, w[1:0]);
			check("masked", {det, ps}, {pm[9] & w[1], pm[11] & w[0]});
			@(posedge core_clk);
			hsize <= 3'h0;
			bus(1'b1, `BSC_OFF_CTRL, ~w);
			hsize <= `BSC_HSIZE_WORD;
			bus(1'b0, `BSC_OFF_CTRL, 32'h0);
			check("byte write", rd, w[1:0]);
			if (!pm[0]) begin
				for (int k = 0; k < 6; k++) begin
					@(posedge core_clk);
					strobe_in <= w[k];
					@(posedge core_clk);
					#1;
					check("raw strobe", strobe_q, w[k]);
				end
			end else begin
				@(posedge core_clk);
				strobe_in <= 1'b1;
				@(posedge core_clk);
				strobe_in <= 1'b0;
				repeat (4) @(posedge core_clk);
				#1;
				check("bounce", strobe_q, 1'b0);
				@(posedge core_clk);
				strobe_in <= 1'b1;
				repeat (DEB) @(posedge core_clk);
				#1;
				check("early", strobe_q, 1'b0);
				@(posedge core_clk);
				#1;
				check("settled", strobe_q, 1'b1);
			end
		end
		stop_test();
	end
endmodule : test_bootstrap_strap_capture
`default_nettype wire

// >>> pkg/bsc_cfg.svh
// constants for the strap capture block
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_STRAP_W 16
`define BSC_USER_W 4
`define BSC_BIT_DEBOUNCE 0
`define BSC_MODE_LSB 1
`define BSC_MODE_MSB 3
`define BSC_ADDR_LSB 4
`define BSC_ADDR_MSB 6
`define BSC_BIT_DETECT 9
`define BSC_BIT_PSAVE 11
`define BSC_MODE_PAR16 3'h0
`define BSC_MODE_PAR8 3'h1
`define BSC_MODE_SER_MII 3'h2
`define BSC_MODE_SER_ONLY 3'h3
`define BSC_MODE_UNMANAGED 3'h7
`define BSC_DEC_W 8
`define BSC_OFF_STATUS 8'h00
`define BSC_OFF_USER 8'h04
`define BSC_OFF_CTRL 8'h08
`define BSC_OFF_RAW 8'h0C
`define BSC_CTRL_W 2
`define BSC_CTRL_RESET 2'h3
`define BSC_CTRL_PSAVE 0
`define BSC_CTRL_DETECT 1
`define BSC_ST_DEBOUNCE 0
`define BSC_ST_MODE_LSB 1
`define BSC_ST_ADDR_LSB 4
`define BSC_ST_DETECT 7
`define BSC_ST_PSAVE 8
`define BSC_ST_INVALID 9
`define BSC_ST_VALID 10
`define BSC_HTRANS_ACT 1
`define BSC_HSIZE_WORD 3'h2
`define BSC_DEB_CYCLES 8
`define BSC_DEB_CNT_W 4
`endif

// >>> pkg/bsc_pkg.sv
// types for the strap capture block
package bsc_pkg;
	typedef enum logic [2:0] {
		BSC_IF_PAR16,
		BSC_IF_PAR8,
		BSC_IF_SER_MII,
		BSC_IF_SER_ONLY,
		BSC_IF_UNMANAGED,
		BSC_IF_INVALID
	} bsc_mgmt_if_type;
	typedef enum logic {
		BSC_DEB_STABLE,
		BSC_DEB_SETTLE
	} bsc_deb_state_type;
endpackage : bsc_pkg

// >>> rtl/bsc_debounce.sv
// debounce filter for the serial management strobe
`timescale 1ns/100ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_debounce #(
	parameter int DEB_CYCLES = `BSC_DEB_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic raw_in,
	output var logic clean_q
);
	bsc_pkg::bsc_deb_state_type state_q;
	logic [`BSC_DEB_CNT_W-1:0] count_q;
	logic at_limit;

	assign at_limit = (count_q == `BSC_DEB_CNT_W'(DEB_CYCLES - 1));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= bsc_pkg::BSC_DEB_STABLE;
			count_q <= '0;
			clean_q <= 1'b0;
		end else if (!enable) begin
			state_q <= bsc_pkg::BSC_DEB_STABLE;
			count_q <= '0;
			clean_q <= raw_in;
		end else begin
			unique case (state_q)
				bsc_pkg::BSC_DEB_STABLE: begin
					count_q <= '0;
					if (raw_in != clean_q) begin
						state_q <= bsc_pkg::BSC_DEB_SETTLE;
					end
				end
				bsc_pkg::BSC_DEB_SETTLE: begin
					if (raw_in == clean_q) begin
						state_q <= bsc_pkg::BSC_DEB_STABLE;
						count_q <= '0;
					end else if (at_limit) begin
						clean_q <= raw_in;
						state_q <= bsc_pkg::BSC_DEB_STABLE;
						count_q <= '0;
					end else begin
						count_q <= count_q + `BSC_DEB_CNT_W'(1);
					end
				end
			endcase
		end
	end
endmodule : bsc_debounce
`default_nettype wire

// >>> rtl/bsc_strap_capture.sv
// strap capture, configuration decode and ahb-lite status registers
//
// Notes on behaviour
// - debounce strap high filters the management strobe; low passes it raw
// - mode code 000 picks 16-bit parallel port, 001 the 8-bit one
// - mode 010: serial management, cpu frames over the mii port
// - mode 011: serial only, cpu frames carried over the serial port
// - mode 111: unmanaged, no cpu frames, eeprom boot load allowed
// - pulled-up strap reads one; lowest mode pin is the code lsb
// - three address straps give the default serial address, lowest pin lsb
// - module-detect strap high enables per-port phy presence detection
// - power-save strap high enables mac power saving, low keeps it off
// - four port transmit-enable pins captured as user bits, readable by software
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_strap_capture #(
	parameter int STRAP_W = `BSC_STRAP_W,
	parameter int USER_W = `BSC_USER_W,
	parameter int DEB_CYCLES = `BSC_DEB_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [STRAP_W-1:0] strap_inputs,
	input wire logic [USER_W-1:0] port_tx_enable_user_strap,
	input wire logic mgmt_strobe_in,
	output var logic mgmt_strobe_q,
	output var logic straps_valid_q,
	output var logic par16_sel_q,
	output var logic par8_sel_q,
	output var logic serial_mii_sel_q,
	output var logic serial_only_sel_q,
	output var logic unmanaged_sel_q,
	output var logic mode_invalid_q,
	output var logic cpu_frames_mii_q,
	output var logic cpu_frames_serial_q,
	output var logic eeprom_boot_allow_q,
	output var logic [2:0] serial_dev_addr_q,
	output var logic module_detect_en_q,
	output var logic mac_power_save_en_q,
	output var logic [USER_W-1:0] user_strap_q,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var logic [31:0] hrdata,
	output var logic hresp
);
	logic capture_done_q;
	logic [STRAP_W-1:0] strap_word_q;
	logic [USER_W-1:0] user_word_q;
	logic [`BSC_CTRL_W-1:0] ctrl_q;
	logic wr_pend_q;
	logic [`BSC_DEC_W-1:0] wr_addr_q;
	logic [2:0] mode_code;
	bsc_pkg::bsc_mgmt_if_type mode_if;
	logic addr_take;
	logic wr_accept;
	logic rd_accept;
	logic ctrl_wr;
	logic [`BSC_CTRL_W-1:0] ctrl_view;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	function automatic logic at_offset(
		input logic [31:0] addr,
		input logic [`BSC_DEC_W-1:0] off
	);
		at_offset = (addr[`BSC_DEC_W-1:0] == off);
	endfunction : at_offset

	function automatic bsc_pkg::bsc_mgmt_if_type mode_of(
		input logic [2:0] code
	);
		unique case (code)
			`BSC_MODE_PAR16: mode_of = bsc_pkg::BSC_IF_PAR16;
			`BSC_MODE_PAR8: mode_of = bsc_pkg::BSC_IF_PAR8;
			`BSC_MODE_SER_MII: mode_of = bsc_pkg::BSC_IF_SER_MII;
			`BSC_MODE_SER_ONLY: mode_of = bsc_pkg::BSC_IF_SER_ONLY;
			`BSC_MODE_UNMANAGED: mode_of = bsc_pkg::BSC_IF_UNMANAGED;
			default: mode_of = bsc_pkg::BSC_IF_INVALID;
		endcase
	endfunction : mode_of

	// capture window: the first edge after reset release
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			capture_done_q <= 1'b0;
		end else begin
			capture_done_q <= 1'b1;
		end
	end

	// strap word, loaded once then frozen
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_word_q <= '0;
		end else if (!capture_done_q) begin
			strap_word_q <= strap_inputs;
		end
	end

	// user strap bits from the port transmit-enable pins
	generate
		for (genvar i = 0; i < USER_W; i++) begin : g_user
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					user_word_q[i] <= 1'b0;
				end else if (!capture_done_q) begin
					user_word_q[i] <= port_tx_enable_user_strap[i];
				end
			end
		end
	endgenerate

	// captured mode code, lowest pin as lsb
	assign mode_code = strap_word_q[`BSC_MODE_MSB:`BSC_MODE_LSB];
	assign mode_if = mode_of(mode_code);

	// strobe conditioning, debounce chosen by the captured strap
	bsc_debounce #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_debounce (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.enable(strap_word_q[`BSC_BIT_DEBOUNCE]),
		.raw_in(mgmt_strobe_in),
		.clean_q(mgmt_strobe_q)
	);

	// valid one edge after the capture edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			straps_valid_q <= 1'b0;
		end else begin
			straps_valid_q <= capture_done_q;
		end
	end

	// management interface selection, one-hot once captured
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			par16_sel_q <= 1'b0;
		end else begin
			par16_sel_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_PAR16);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			par8_sel_q <= 1'b0;
		end else begin
			par8_sel_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_PAR8);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_mii_sel_q <= 1'b0;
		end else begin
			serial_mii_sel_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_SER_MII);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_only_sel_q <= 1'b0;
		end else begin
			serial_only_sel_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_SER_ONLY);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unmanaged_sel_q <= 1'b0;
		end else begin
			unmanaged_sel_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_UNMANAGED);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_invalid_q <= 1'b0;
		end else begin
			mode_invalid_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_INVALID);
		end
	end

	// cpu frame path and boot load permission
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_frames_mii_q <= 1'b0;
		end else begin
			cpu_frames_mii_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_SER_MII);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_frames_serial_q <= 1'b0;
		end else begin
			cpu_frames_serial_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_SER_ONLY);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			eeprom_boot_allow_q <= 1'b0;
		end else begin
			eeprom_boot_allow_q <= capture_done_q && (mode_if == bsc_pkg::BSC_IF_UNMANAGED);
		end
	end

	// default serial device address
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_dev_addr_q <= '0;
		end else begin
			serial_dev_addr_q <= strap_word_q[`BSC_ADDR_MSB:`BSC_ADDR_LSB];
		end
	end

	// feature enables, each gated by its software mask
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			module_detect_en_q <= 1'b0;
		end else begin
			module_detect_en_q <= capture_done_q && strap_word_q[`BSC_BIT_DETECT]
				&& ctrl_q[`BSC_CTRL_DETECT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mac_power_save_en_q <= 1'b0;
		end else begin
			mac_power_save_en_q <= capture_done_q && strap_word_q[`BSC_BIT_PSAVE]
				&& ctrl_q[`BSC_CTRL_PSAVE];
		end
	end

	// captured user bits to the port
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			user_strap_q <= '0;
		end else begin
			user_strap_q <= user_word_q;
		end
	end

	// ahb-lite slave: zero wait states, always okay
	assign addr_take = hsel && hready && htrans[`BSC_HTRANS_ACT];

	assign wr_accept = addr_take && hwrite && (hsize == `BSC_HSIZE_WORD);
	assign rd_accept = addr_take && !hwrite;

	// write address held over for the data phase
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_accept;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_addr_q <= '0;
		end else begin
			wr_addr_q <= haddr[`BSC_DEC_W-1:0];
		end
	end

	assign ctrl_wr = wr_pend_q && (wr_addr_q == `BSC_OFF_CTRL);

	// software masks for detect and power save
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= `BSC_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= hwdata[`BSC_CTRL_W-1:0];
		end
	end

	// forward a write landing in the same cycle as the next read
	assign ctrl_view = ctrl_wr ? hwdata[`BSC_CTRL_W-1:0] : ctrl_q;

	// status word for software
	always_comb begin
		status_word = '0;
		status_word[`BSC_ST_DEBOUNCE] = strap_word_q[`BSC_BIT_DEBOUNCE];
		status_word[`BSC_ST_MODE_LSB +: 3] = mode_code;
		status_word[`BSC_ST_ADDR_LSB +: 3] = strap_word_q[`BSC_ADDR_MSB:`BSC_ADDR_LSB];
		status_word[`BSC_ST_DETECT] = strap_word_q[`BSC_BIT_DETECT];
		status_word[`BSC_ST_PSAVE] = strap_word_q[`BSC_BIT_PSAVE];
		status_word[`BSC_ST_INVALID] = (mode_if == bsc_pkg::BSC_IF_INVALID);
		status_word[`BSC_ST_VALID] = capture_done_q;
	end

	// read mux on the low address byte
	always_comb begin
		rd_word = '0;
		if (at_offset(haddr, `BSC_OFF_STATUS)) begin
			rd_word = status_word;
		end else if (at_offset(haddr, `BSC_OFF_USER)) begin
			rd_word[USER_W-1:0] = user_word_q;
		end else if (at_offset(haddr, `BSC_OFF_CTRL)) begin
			rd_word[`BSC_CTRL_W-1:0] = ctrl_view;
		end else if (at_offset(haddr, `BSC_OFF_RAW)) begin
			rd_word[STRAP_W-1:0] = strap_word_q;
		end
	end

	// read data registered at the address edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= '0;
		end else if (rd_accept) begin
			hrdata <= rd_word;
		end
	end

	// no wait states, response always okay
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end
endmodule : bsc_strap_capture
`default_nettype wire
